/* File: src/nax_pkg.sv */
package nax_pkg;
	// Opcodes (first byte; OP_OR2 is the byte after OP_PFX)
	localparam logic [7:0] OP_ASC   = 8'h30;
	localparam logic [7:0] OP_ADD   = 8'h31;
	localparam logic [7:0] OP_RC    = 8'h32;
	localparam logic [7:0] OP_PFX   = 8'h33;
	localparam logic [7:0] OP_SC    = 8'h22;
	localparam logic [7:0] OP_XOR   = 8'h02;
	localparam logic [7:0] OP_ADT   = 8'h4A;
	localparam logic [7:0] OP_COMPLEMENT_SUM_SKIP  = 8'h10;
	localparam logic [7:0] OP_ZERO_ACC_OP  = 8'h00;
	localparam logic [7:0] OP_COMP  = 8'h40;
	localparam logic [7:0] OP_NOP   = 8'h44;
	localparam logic [7:0] OP_JID   = 8'hFF;
	localparam logic [7:0] OP_OR2   = 8'h1A;
	// Opcode groups: IMMEDIATE_SUM_SKIP 0x5y (y!=0), DIRECT_JUMP_OP 0x6x with 0..7 in low bits
	localparam logic [3:0] HI_IMMEDIATE_SUM_SKIP  = 4'h5;
	localparam logic [4:0] HI_JMP   = 5'h0C;
	// Constants
	localparam logic [3:0] TEN      = 4'hA;
	localparam logic [3:0] ACC_RST  = 4'h0;
	localparam logic [10:0] PC_RST  = 11'h000;
	// Device groups
	localparam logic [1:0] GRP_1    = 2'd0;
	localparam logic [1:0] GRP_3    = 2'd2;
	// Instruction cycle divider
	localparam int CORE_MHZ         = 250;
	localparam int ICYC_NS          = 4000;
	localparam int ICYC_CLKS        = ICYC_NS * CORE_MHZ / 1000;
endpackage

/* File: src/nax_core.sv */
`timescale 1ns/1ns
// Behaviour
// - 0x30 adds A, carry and RAM; carry from bit three; skip when set
// - 0x31 adds RAM to A, carry untouched, no skip, one cycle
// - Decimal adjust adds ten to A, keeps low four bits
// - Add immediate to A, carry untouched, skip on carry out of bit three
// - Subtract adds inverted A, RAM and carry; skip on carry; absent in group one
// - Complement inverts A, carry untouched, one cycle, no skip
// - OR is 0x33 0x1A, ORs RAM into A, two cycles, group three only
// - 0x32 clears carry, A untouched, one cycle
// - 0x22 sets carry, A untouched, one cycle
// - 0x02 XORs RAM into A, carry untouched, one cycle
// - Indirect jump increments PC then loads low byte with A and RAM
// - Indirect jump then loads low byte from ROM word; two cycles
// - Increment before replacement makes block-end jumps use the next block
// - Direct jump loads eleven PC bits from address field, carry untouched
// - RAM pointer splits into row and four-bit digit fields
// - Eight-bit latch holds data for the L port
// - A met skip condition suppresses the following instruction
module nax_core
	import nax_pkg::*;
#(
	parameter int ROW_W  = 2,
	parameter int ICYC   = nax_pkg::ICYC_CLKS
)
(
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire logic [1:0]        i_dev_group,
	input  wire logic [10:0]       i_rom_data_pc,
	input  wire logic [7:0]        i_rom_data,
	input  wire logic [3:0]        i_ram_data,
	input  wire logic              i_l_load,
	input  wire logic [7:0]        i_l_data,
	output logic      [10:0]       o_rom_addr,
	output logic      [ROW_W-1:0]  o_register_row_field,
	output logic      [3:0]        o_digit_column_field,
	input  wire logic [ROW_W+3:0]  i_ram_ptr,
	output logic      [3:0]        o_acc,
	output logic                   o_carry,
	output logic      [7:0]        o_l_latch,
	output logic                   o_icyc_en
);
	import nax_pkg::*;

	initial
	begin
		// Divider counter is sixteen bits wide
		if (ROW_W < 1 || ROW_W > 4 || ICYC < 2 || ICYC > 65536)
			$error("nax_core: unsupported parameter");
	end

	typedef enum logic [4:0]
	{
		ST_FETCH = 5'b00001,
		ST_PFX   = 5'b00010,
		ST_JMP2  = 5'b00100,
		ST_VEC   = 5'b01000,
		ST_SKIP2 = 5'b10000
	} nax_state_t;

	nax_state_t  state_q, state_d;
	logic [3:0]  acc_q, acc_d;
	logic        c_q, c_d;
	logic        skip_q, skip_d;
	logic [10:0] pc_q, pc_d;
	logic [2:0]  jhi_q, jhi_d;
	logic [7:0]  l_q, l_d;
	logic [15:0] div_q, div_d;
	logic        tick;
	logic [7:0]  op;
	logic [4:0]  sum;

	// Four-bit add with carry in, five-bit result
	function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b,
		input logic ci);
		add4 = {1'b0, a} + {1'b0, b} + {4'b0, ci};
	endfunction

	// Opcodes that carry a second byte
	function automatic logic two_byte(input logic [7:0] o);
		two_byte = (o == OP_PFX) || (o[7:3] == HI_JMP);
	endfunction

	// Instruction cycle enable divider
	always_comb
	begin
		tick  = (div_q == 16'(ICYC - 1));
		div_d = tick ? 16'h0000 : div_q + 16'h0001;
	end

	assign op = i_rom_data;

	// L port latch next value
	always_comb
	begin
		l_d = i_l_load ? i_l_data : l_q;
	end

	// Pointer fields and memory operand
	assign o_register_row_field = i_ram_ptr[ROW_W+3:4];
	assign o_digit_column_field = i_ram_ptr[3:0];

	// Execute next state
	always_comb
	begin
		state_d = state_q;
		acc_d   = acc_q;
		c_d     = c_q;
		skip_d  = skip_q;
		pc_d    = pc_q;
		jhi_d   = jhi_q;
		sum     = 5'h00;
		if (tick)
		begin
			case (state_q)
				ST_FETCH:
				begin
					pc_d = pc_q + 11'h001;
					if (skip_q)
					begin
						// Suppressed opcode; a two-byte one drops its operand too
						skip_d = 1'b0;
						if (two_byte(op))
							state_d = ST_SKIP2;
					end
					else if (op == OP_ASC)
					begin
						// Add with carry; carry out sets carry and skip
						sum    = add4(acc_q, i_ram_data, c_q);
						acc_d  = sum[3:0];
						c_d    = sum[4];
						skip_d = sum[4];
					end
					else if (op == OP_ADD)
					begin
						// Plain add, carry ignored
						sum   = add4(acc_q, i_ram_data, 1'b0);
						acc_d = sum[3:0];
					end
					else if (op == OP_ADT)
					begin
						// Decimal adjust, binary add of ten
						sum   = add4(acc_q, TEN, 1'b0);
						acc_d = sum[3:0];
					end
					else if (op[7:4] == HI_IMMEDIATE_SUM_SKIP && op[3:0] != 4'h0)
					begin
						// Immediate add; carry out only skips
						sum    = add4(acc_q, op[3:0], 1'b0);
						acc_d  = sum[3:0];
						skip_d = sum[4];
					end
					else if (op == OP_COMPLEMENT_SUM_SKIP && i_dev_group != GRP_1)
					begin
						// Subtract via inverted accumulator
						sum    = add4(~acc_q, i_ram_data, c_q);
						acc_d  = sum[3:0];
						c_d    = sum[4];
						skip_d = sum[4];
					end
					else if (op == OP_ZERO_ACC_OP)
					begin
						// Clear accumulator
						acc_d = ACC_RST;
					end
					else if (op == OP_COMP)
					begin
						// One's complement
						acc_d = ~acc_q;
					end
					else if (op == OP_RC)
					begin
						// Carry reset
						c_d = 1'b0;
					end
					else if (op == OP_SC)
					begin
						// Carry set
						c_d = 1'b1;
					end
					else if (op == OP_XOR)
					begin
						// Bitwise exclusive OR with memory
						acc_d = acc_q ^ i_ram_data;
					end
					else if (op == OP_PFX)
					begin
						// Prefix; second byte decoded next cycle
						state_d = ST_PFX;
					end
					else if (op == OP_JID)
					begin
						// Increment first, then replace the low byte
						pc_d    = {pc_q[10:8] + 3'(pc_q[7:0] == 8'hFF), acc_q, i_ram_data};
						state_d = ST_VEC;
					end
					else if (op[7:3] == HI_JMP)
					begin
						// Direct jump; keep high address bits
						jhi_d   = op[2:0];
						state_d = ST_JMP2;
					end
				end
				ST_PFX:
				begin
					pc_d    = pc_q + 11'h001;
					state_d = ST_FETCH;
					if (op == OP_OR2 && i_dev_group == GRP_3)
						acc_d = acc_q | i_ram_data;
				end
				ST_JMP2:
				begin
					pc_d    = {jhi_q, op};
					state_d = ST_FETCH;
				end
				ST_VEC:
				begin
					// Vector word replaces low byte after a further increment
					pc_d    = {pc_q[10:8] + 3'(pc_q[7:0] == 8'hFF), op};
					state_d = ST_FETCH;
				end
				ST_SKIP2:
				begin
					// Operand byte of a suppressed two-byte opcode
					pc_d    = pc_q + 11'h001;
					state_d = ST_FETCH;
				end
				default:
				begin
					state_d = ST_FETCH;
				end
			endcase
		end
	end

	// Divider register
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			div_q <= 16'h0000;
		else
			div_q <= div_d;
	end

	// L port latch register
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			l_q <= 8'h00;
		else
			l_q <= l_d;
	end

	// Execute state registers
	always_ff @(posedge i_core_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q <= ST_FETCH;
			acc_q   <= ACC_RST;
			c_q     <= 1'b0;
			skip_q  <= 1'b0;
			pc_q    <= PC_RST;
			jhi_q   <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			acc_q   <= acc_d;
			c_q     <= c_d;
			skip_q  <= skip_d;
			pc_q    <= pc_d;
			jhi_q   <= jhi_d;
		end
	end

	// Outputs
	assign o_rom_addr = pc_q;
	assign o_acc      = acc_q;
	assign o_carry    = c_q;
	assign o_l_latch  = l_q;
	assign o_icyc_en  = tick;

	logic unused_ok;
	assign unused_ok = |i_rom_data_pc;
endmodule // nax_core

/* File: dv/nax_core_assertions.sv */
`timescale 1ns/1ns
module nax_chk
	import nax_pkg::*;
#(parameter int ROW_W = 2, parameter int ICYC = 4)
(
	input wire logic             i_core_clk,
	input wire logic             i_resetn,
	input wire logic [1:0]       i_dev_group,
	input wire logic [7:0]       i_rom_data,
	input wire logic [3:0]       i_ram_data,
	input wire logic             i_l_load,
	input wire logic [7:0]       i_l_data,
	input wire logic [ROW_W+3:0] i_ram_ptr,
	input wire logic [10:0]      o_rom_addr,
	input wire logic [ROW_W-1:0] o_register_row_field,
	input wire logic [3:0]       o_digit_column_field,
	input wire logic [3:0]       o_acc,
	input wire logic             o_carry,
	input wire logic [7:0]       o_l_latch,
	input wire logic             o_icyc_en
);
	int         c_q, c_d;
	logic       s_q, s_d, b_q, b_d, ok;
	logic [7:0] op;
	assign op = i_rom_data;
	assign ok = o_icyc_en && !b_q;
	// Gap count, first tick seen, next tick maybe not a first byte
	always_comb
	begin
		c_d = o_icyc_en ? 0 : c_q + 1;
		s_d = s_q | o_icyc_en;
		b_d = o_icyc_en ? (op == OP_ASC || op == OP_COMPLEMENT_SUM_SKIP || op == OP_PFX || op == OP_JID
			|| op[7:4] == HI_IMMEDIATE_SUM_SKIP || op[7:3] == HI_JMP) : b_q;
	end
	always_ff @(posedge i_core_clk or negedge i_resetn)
		if (!i_resetn)
			{c_q, s_q, b_q} <= '0;
		else
			{c_q, s_q, b_q} <= {c_d, s_d, b_d};
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	AST_TICK: assert property (s_q |-> c_q < ICYC && o_icyc_en == (c_q == ICYC - 1))
		else $error("tick gap");
	AST_STAB: assert property (!o_icyc_en |=> $stable({o_acc, o_carry, o_rom_addr}))
		else $error("state moved off tick");
	AST_LAT: assert property (i_l_load |=> o_l_latch == $past(i_l_data))
		else $error("latch load");
	AST_PTR: assert property ({o_register_row_field, o_digit_column_field} == i_ram_ptr)
		else $error("pointer split");
	AST_ASC: assert property (ok && op == OP_ASC |=>
		{o_carry, o_acc} == $past(o_acc) + $past(o_carry) + $past(i_ram_data)) else $error("asc");
	AST_ADD: assert property (ok && op == OP_ADD |=>
		o_acc == $past(o_acc) + $past(i_ram_data) && $stable(o_carry)) else $error("add");
	AST_COMPLEMENT_SUM_SKIP: assert property (ok && op == OP_COMPLEMENT_SUM_SKIP && i_dev_group != GRP_1 |=>
		{o_carry, o_acc} == 4'(~$past(o_acc)) + $past(i_ram_data) + $past(o_carry))
		else $error("complement_sum_skip");
	AST_IMMEDIATE_SUM_SKIP: assert property (ok && op[7:4] == HI_IMMEDIATE_SUM_SKIP && op[3:0] != 4'h0 |=>
		o_acc == $past(o_acc) + $past(i_rom_data[3:0]) && $stable(o_carry)) else $error("immediate_sum_skip");
	AST_RC: assert property (ok && op == OP_RC |=> !o_carry && $stable(o_acc))
		else $error("rc");
	AST_SC: assert property (ok && op == OP_SC |=> o_carry && $stable(o_acc))
		else $error("sc");
	// Main scenarios reached
	cover property (ok && op == OP_ASC ##1 o_carry);
	cover property (ok && op == OP_JID);
	cover property (ok && op == OP_PFX);
endmodule // nax_chk
bind nax_core nax_chk #(.ROW_W(ROW_W), .ICYC(ICYC)) u_chk (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import nax_pkg::*;
	logic        clk = 1'h0, rstn = 1'h0, l_ld = 1'h0, cy, tick;
	logic [1:0]  grp = GRP_3, row;
	logic [3:0]  ram = 4'h0, acc, dig;
	logic [5:0]  ptr = 6'h00;
	logic [7:0]  l_d = 8'h00, lat, rd, rom [0:2047];
	logic [10:0] pc;
	int          err_count = 0, n_checks = 0, cyc = 0;
	assign rd = rom[pc];
	// Core clock
	always #2 clk = ~clk;
	nax_core #(.ROW_W(2), .ICYC(4)) DUT (.i_core_clk(clk), .i_resetn(rstn),
		.i_dev_group(grp), .i_rom_data_pc(11'h000), .i_rom_data(rd), .i_ram_data(ram),
		.i_l_load(l_ld), .i_l_data(l_d), .o_rom_addr(pc), .o_register_row_field(row),
		.o_digit_column_field(dig), .i_ram_ptr(ptr), .o_acc(acc), .o_carry(cy),
		.o_l_latch(lat), .o_icyc_en(tick));
	task chk(input logic [15:0] g, e);
		n_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task rst(input logic [1:0] g, input logic [7:0] p[$]);
		rstn = 1'h0;
		grp = g;
		foreach (rom[i]) rom[i] = OP_NOP;
		foreach (p[i]) rom[i] = p[i];
		repeat (20) @(negedge clk);
		rstn = 1'h1;
	endtask
	task tk(input int n);
		repeat (n) @(posedge clk iff tick === 1'h1);
		@(negedge clk);
	endtask
	task t_arith;
		ram = 4'h9;
		rst(GRP_3, '{8'h5F, 8'h5F, OP_COMP, OP_ASC, OP_ZERO_ACC_OP, OP_ADD, OP_ADT, OP_XOR, OP_COMP, OP_RC});
		tk(5);
		chk({cy, acc, pc}, {1'h1, 4'h7, 11'h005});
		tk(5);
		chk({cy, acc, pc}, {1'h0, 4'hC, 11'h00A});
		$display("arith done");
	endtask
	task t_sub(input logic [1:0] g, input logic [15:0] e);
		ram = 4'h5;
		rst(g, '{OP_SC, OP_COMPLEMENT_SUM_SKIP, OP_COMP, OP_ZERO_ACC_OP, OP_PFX, OP_OR2});
		tk(3);
		chk({cy, acc, pc}, e);
		if (g == GRP_3)
		begin
			tk(3);
			chk({cy, acc, pc}, {1'h1, 4'h5, 11'h006});
		end
		$display("subtract done");
	endtask
	task t_jump;
		ram = 4'h7;
		rst(GRP_3, '{8'h53, 8'h64, 8'hFF});
		rom[11'h4FF] = OP_JID;
		rom[11'h537] = 8'h12;
		tk(3);
		chk({cy, acc, pc}, {1'h0, 4'h3, 11'h4FF});
		tk(2);
		chk({cy, acc, pc}, {1'h0, 4'h3, 11'h512});
		$display("jump done");
	endtask
	task t_skip2;
		ram = 4'h0;
		rst(GRP_3, '{8'h5F, 8'h5F, 8'h64, OP_ZERO_ACC_OP, OP_COMP});
		tk(5);
		chk({cy, acc, pc}, {1'h0, 4'h1, 11'h005});
		$display("skip done");
	endtask
	task t_port;
		rst(GRP_3, '{OP_NOP});
		ptr = 6'h2B;
		l_d = 8'hA5;
		l_ld = 1'h1;
		@(negedge clk);
		l_ld = 1'h0;
		chk({2'h0, lat, row, dig}, {2'h0, 8'hA5, 2'h2, 4'hB});
		$display("port done");
	endtask
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			final_report;
		end
	end
	initial
	begin
		t_arith;
		t_sub(GRP_3, {1'h1, 4'h5, 11'h003});
		t_sub(GRP_1, {1'h1, 4'hF, 11'h003});
		t_jump;
		t_skip2;
		t_port;
		final_report;
	end
endmodule // tb_top
